// >>> logic/ddrmrs_params.svh
/*
  timing counts and field positions for the mode register bank.
  assumes inclusion by bare name from logic/.
*/
`ifndef DDRMRS_PARAMS_SVH
`define DDRMRS_PARAMS_SVH
`define DDRMRS_ADDR_W        13
`define DDRMRS_BA_W          3
`define DDRMRS_MRD_CK        2
`define DDRMRS_BL_LO         0
`define DDRMRS_BL_HI         2
`define DDRMRS_BT_BIT        3
`define DDRMRS_CL_LO         4
`define DDRMRS_CL_HI         6
`define DDRMRS_TM_BIT        7
`define DDRMRS_DLLRST_BIT    8
`define DDRMRS_WR_LO         9
`define DDRMRS_WR_HI         11
`define DDRMRS_DLLDIS_BIT    0
`define DDRMRS_HALF_BIT      1
`define DDRMRS_RTT0_BIT      2
`define DDRMRS_AL_LO         3
`define DDRMRS_AL_HI         5
`define DDRMRS_RTT1_BIT      6
`define DDRMRS_CAL_LO        7
`define DDRMRS_CAL_HI        9
`define DDRMRS_NDQS_BIT      10
`define DDRMRS_OUTDIS_BIT    12
`define DDRMRS_PARTIAL_ARRAY_SELF_REFRESH_LO       0
`define DDRMRS_PARTIAL_ARRAY_SELF_REFRESH_HI       2
`define DDRMRS_DCC_BIT       3
`define DDRMRS_HTSR_BIT      7
`define DDRMRS_CAL_ADJUST    3'h4
`define DDRMRS_CAL_EXIT      3'h0
`define DDRMRS_SEL_MAIN      2'h0
`define DDRMRS_SEL_ONE       2'h1
`define DDRMRS_SEL_TWO       2'h2
`define DDRMRS_SEL_THREE     2'h3
`endif

// >>> logic/ddrmrs_pkg.sv
/*
  types for the mode register bank.
  assumes the params header is available.
*/
package ddrmrs_pkg;
  typedef logic [12:0] ddrmrs_word_t;
  typedef enum logic [1:0] {
    DDRMRS_SR_OUT,
    DDRMRS_SR_IN
  } ddrmrs_sr_t;
endpackage

// >>> logic/ddrmrs_sync.sv
/*
  two-flop synchroniser for a bus of pin inputs.
  assumes the data are asynchronous to core_clk.
*/
`timescale 1ns/10ps
module ddrmrs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// >>> logic/ddrmrs_top.sv
/*
  mode and extended mode register bank of a ddr2 sdram: decodes register
  write commands sampled on rising ck edges and drives the decoded fields.
  assumes the controller only writes when idle with cke high, and respects
  the register write cycle time; ck is sampled by core_clk.
*/
`timescale 1ns/10ps
`include "ddrmrs_params.svh"
module ddrmrs_top
  import ddrmrs_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // memory command pins
  input  wire logic        ck,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [12:0] addr,
  // main register fields
  output logic [2:0]       burst_length,
  output logic             burst_interleave,
  output logic [2:0]       cas_latency,
  output logic             test_mode,
  output logic             dll_reset,
  output logic [2:0]       write_recovery,
  // register one fields
  output logic             dll_enable,
  output logic             half_strength,
  output logic [2:0]       additive_latency,
  output logic [1:0]       termination_sel,
  output logic [2:0]       driver_calibration,
  output logic             strobe_n_disable,
  output logic             output_disable,
  // register two and three
  output logic [2:0]       partial_array_self_refresh,
  output logic             duty_cycle_corrector,
  output logic             high_temp_refresh,
  output logic [12:0]      ext_three_word,
  // status
  output logic             self_refresh,
  output logic             reg_write_pulse
);
  localparam int SYNC_W = 22;

  logic [SYNC_W-1:0] pins_s;
  logic              ck_s;
  logic              ck_prev_q;
  logic              cke_s;
  logic              cke_prev_q;
  logic              cs_s;
  logic              ras_s;
  logic              cas_s;
  logic              we_s;
  logic [2:0]        ba_s;
  ddrmrs_word_t      addr_s;

  ddrmrs_word_t main_q;
  ddrmrs_word_t one_q;
  ddrmrs_word_t one_d;
  ddrmrs_word_t two_q;
  ddrmrs_word_t three_q;
  ddrmrs_sr_t   sr_q;
  ddrmrs_sr_t   sr_d;

  ddrmrs_sync #(
    .W (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr}),
    .sync_out (pins_s)
  );

  assign {ck_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s, addr_s} = pins_s;

  wire ck_rise   = ck_s & ~ck_prev_q;
  wire cmd_valid = ck_rise & cke_prev_q & cke_s & ~cs_s;
  // register write: all strobes low, top bank bit low
  wire mrs_cmd   = cmd_valid & ~ras_s & ~cas_s & ~we_s & ~ba_s[2];
  wire ref_cmd   = ck_rise & cke_prev_q & ~cs_s & ~ras_s & ~cas_s & we_s;
  wire sr_entry  = ref_cmd & ~cke_s;
  wire sr_exit   = ck_rise & ~cke_prev_q & cke_s & (cs_s | (ras_s & cas_s & we_s));
  wire wr_main   = mrs_cmd & (ba_s[1:0] == `DDRMRS_SEL_MAIN);
  wire wr_one    = mrs_cmd & (ba_s[1:0] == `DDRMRS_SEL_ONE);
  wire wr_two    = mrs_cmd & (ba_s[1:0] == `DDRMRS_SEL_TWO);
  wire wr_three  = mrs_cmd & (ba_s[1:0] == `DDRMRS_SEL_THREE);
  wire cal_adj   = addr_s[`DDRMRS_CAL_HI:`DDRMRS_CAL_LO] == `DDRMRS_CAL_ADJUST;

  // adjust-mode write keeps the old latency field
  always_comb begin
    one_d = addr_s;
    if (cal_adj) begin
      one_d[`DDRMRS_AL_HI:`DDRMRS_AL_LO] = one_q[`DDRMRS_AL_HI:`DDRMRS_AL_LO];
    end
  end

  always_comb begin
    sr_d = sr_q;
    unique case (sr_q)
      DDRMRS_SR_OUT: if (sr_entry) sr_d = DDRMRS_SR_IN;
      DDRMRS_SR_IN:  if (sr_exit) sr_d = DDRMRS_SR_OUT;
      default:       sr_d = DDRMRS_SR_OUT;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ck_prev_q  <= 1'b0;
      cke_prev_q <= 1'b0;
      sr_q       <= DDRMRS_SR_OUT;
    end else begin
      ck_prev_q  <= ck_s;
      if (ck_rise) begin
        cke_prev_q <= cke_s;
      end
      sr_q       <= sr_d;
    end
  end

  // registers have no reset; contents undefined until written
  always_ff @(posedge core_clk) begin
    if (wr_main) begin
      main_q <= addr_s;
    end
    if (wr_one) begin
      one_q <= one_d;
    end
    if (wr_two) begin
      two_q <= addr_s;
    end
    if (wr_three) begin
      three_q <= addr_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      burst_length               <= 3'h0;
      burst_interleave           <= 1'b0;
      cas_latency                <= 3'h0;
      test_mode                  <= 1'b0;
      dll_reset                  <= 1'b0;
      write_recovery             <= 3'h0;
      dll_enable                 <= 1'b0;
      half_strength              <= 1'b0;
      additive_latency           <= 3'h0;
      termination_sel            <= 2'h0;
      driver_calibration         <= 3'h0;
      strobe_n_disable           <= 1'b0;
      output_disable             <= 1'b0;
      partial_array_self_refresh <= 3'h0;
      duty_cycle_corrector       <= 1'b0;
      high_temp_refresh          <= 1'b0;
      ext_three_word             <= 13'h0000;
      self_refresh               <= 1'b0;
      reg_write_pulse            <= 1'b0;
    end else begin
      burst_length       <= main_q[`DDRMRS_BL_HI:`DDRMRS_BL_LO];
      burst_interleave   <= main_q[`DDRMRS_BT_BIT];
      cas_latency        <= main_q[`DDRMRS_CL_HI:`DDRMRS_CL_LO];
      test_mode          <= main_q[`DDRMRS_TM_BIT];
      dll_reset          <= main_q[`DDRMRS_DLLRST_BIT];
      write_recovery     <= main_q[`DDRMRS_WR_HI:`DDRMRS_WR_LO];
      // dll low-true enable bit, forced off in self refresh
      dll_enable         <= ~one_q[`DDRMRS_DLLDIS_BIT] & (sr_q == DDRMRS_SR_OUT);
      half_strength      <= one_q[`DDRMRS_HALF_BIT];
      additive_latency   <= one_q[`DDRMRS_AL_HI:`DDRMRS_AL_LO];
      termination_sel    <= {one_q[`DDRMRS_RTT1_BIT], one_q[`DDRMRS_RTT0_BIT]};
      driver_calibration <= one_q[`DDRMRS_CAL_HI:`DDRMRS_CAL_LO];
      strobe_n_disable   <= one_q[`DDRMRS_NDQS_BIT];
      output_disable     <= one_q[`DDRMRS_OUTDIS_BIT];
      partial_array_self_refresh <= two_q[`DDRMRS_PARTIAL_ARRAY_SELF_REFRESH_HI:`DDRMRS_PARTIAL_ARRAY_SELF_REFRESH_LO];
      duty_cycle_corrector <= two_q[`DDRMRS_DCC_BIT];
      high_temp_refresh  <= two_q[`DDRMRS_HTSR_BIT];
      ext_three_word     <= three_q;
      self_refresh       <= (sr_q == DDRMRS_SR_IN);
      reg_write_pulse    <= mrs_cmd;
    end
  end
endmodule

// >>> test/ddrmrs_top_sva.sv
/* checker for the mode register bank top.
   bound to ddrmrs_top; sees its ports only. */
`timescale 1ns/10ps
module ddrmrs_top_sva (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // memory command pins
  input wire logic        ck,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  ba,
  input wire logic [12:0] addr,
  // main register fields
  input wire logic [2:0]  burst_length,
  input wire logic        burst_interleave,
  input wire logic [2:0]  cas_latency,
  input wire logic        test_mode,
  input wire logic        dll_reset,
  input wire logic [2:0]  write_recovery,
  // register one fields
  input wire logic        dll_enable,
  input wire logic        half_strength,
  input wire logic [2:0]  additive_latency,
  input wire logic [1:0]  termination_sel,
  input wire logic [2:0]  driver_calibration,
  input wire logic        strobe_n_disable,
  input wire logic        output_disable,
  // register two and three
  input wire logic [2:0]  partial_array_self_refresh,
  input wire logic        duty_cycle_corrector,
  input wire logic        high_temp_refresh,
  input wire logic [12:0] ext_three_word,
  // status
  input wire logic        self_refresh,
  input wire logic        reg_write_pulse
);
  logic ck_q, cke_q;
  logic [12:0] cap_q;
  logic [1:0] sel_q;
  wire rise = ck && !ck_q;
  wire cmd = rise && !cs_n && !ras_n && !cas_n && !we_n && cke && cke_q;
  wire wr = cmd && !ba[2];
  wire p0 = reg_write_pulse && sel_q == 2'h0;
  wire p1 = reg_write_pulse && sel_q == 2'h1;
  always_ff @(posedge core_clk) begin
    ck_q <= ck;
    if (rise) cke_q <= cke;
    if (wr) cap_q <= addr;
    if (wr) sel_q <= ba[1:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_take; wr |-> ##[2:6] reg_write_pulse; endproperty
  a_take: assert property (p_take) else $error("write not taken");
  property p_refuse; cmd && ba[2] |-> !reg_write_pulse [*7]; endproperty
  a_refuse: assert property (p_refuse) else $error("reserved bank taken");
  property p_pulse; reg_write_pulse |=> !reg_write_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  // field outputs settle one cycle after the write pulse
  property p_main; p0 |=> {write_recovery, dll_reset, test_mode, cas_latency,
    burst_interleave, burst_length} == cap_q[11:0]; endproperty
  a_main: assert property (p_main) else $error("main fields bad");
  property p_one; p1 && !self_refresh |=> {output_disable, strobe_n_disable,
    driver_calibration, termination_sel[1], termination_sel[0], half_strength,
    ~dll_enable} == {cap_q[12], cap_q[10:6], cap_q[2:0]}; endproperty
  a_one: assert property (p_one) else $error("reg one fields wrong");
  property p_adj; p1 && cap_q[9:7] == 3'h4 |=> $stable(additive_latency); endproperty
  a_adj: assert property (p_adj) else $error("latency changed on adjust");
  property p_al; p1 && cap_q[9:7] != 3'h4 |=> additive_latency == cap_q[5:3]; endproperty
  a_al: assert property (p_al) else $error("latency wrong");
  property p_two; reg_write_pulse && sel_q == 2'h2 |=> {high_temp_refresh,
    duty_cycle_corrector, partial_array_self_refresh} == {cap_q[7], cap_q[3:0]}; endproperty
  a_two: assert property (p_two) else $error("register two wrong");
  property p_three; reg_write_pulse && sel_q == 2'h3 |=> ext_three_word == cap_q; endproperty
  a_three: assert property (p_three) else $error("register three wrong");
  property p_sr; self_refresh [*2] |-> !dll_enable; endproperty
  a_sr: assert property (p_sr) else $error("dll on in self refresh");
endmodule
bind ddrmrs_top ddrmrs_top_sva u_sva (.*);

// >>> test/ddrmrs_ctl_model.sv
/* controller stand-in driving ck and the command pins.
   assumes core_clk from the bench; pins move on its falling edge. */
`timescale 1ns/10ps
module ddrmrs_ctl_model (
  // clock
  input  wire logic   core_clk,
  // memory command pins
  output logic        ck,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [12:0] addr
);
  initial begin
    ck = 1'b0;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    addr = 13'h0000;
  end
  // command period, then a deselect period; ck idles low between calls
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
                       input logic k);
    @(negedge core_clk);
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    cke = k;
    for (int i = 0; i < 2; i++) begin
      repeat (4) @(negedge core_clk);
      ck = 1'b1;
      repeat (4) @(negedge core_clk);
      ck = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      ba = ~b;
      addr = ~addr;
    end
  endtask
endmodule

// >>> test/ddrmrs_top_tb.sv
/* self-checking bench for the mode register bank.
   pins come from the controller model; core_clk period 100 ns. */
`timescale 1ns/10ps
module ddrmrs_top_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ck, cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0] ba, burst_length, cas_latency, write_recovery, additive_latency;
  logic [2:0] driver_calibration, partial_array_self_refresh;
  logic [1:0] termination_sel;
  logic [12:0] addr, ext_three_word;
  logic burst_interleave, test_mode, dll_reset, dll_enable, half_strength;
  logic strobe_n_disable, output_disable, duty_cycle_corrector, high_temp_refresh;
  logic self_refresh, reg_write_pulse;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire [12:0] main_v = {1'b0, write_recovery, dll_reset, test_mode, cas_latency,
                        burst_interleave, burst_length};
  wire [12:0] one_v = {output_disable, 1'b0, strobe_n_disable, driver_calibration,
    termination_sel[1], additive_latency, termination_sel[0], half_strength, ~dll_enable};
  wire [12:0] two_v = {5'h00, high_temp_refresh, 3'h0, duty_cycle_corrector,
                       partial_array_self_refresh};
  always #50 core_clk = ~core_clk;
  ddrmrs_top u_dut (.*);
  ddrmrs_ctl_model u_ctl (.*);
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wchk(input logic [1:0] sel, input logic [12:0] w);
    u_ctl.issue(4'h0, {1'b0, sel}, w, 1'b1);
    case (sel)
      2'h0: chk(main_v, {1'b0, w[11:0]});
      2'h1: chk(one_v, w & 13'h17FF);
      2'h2: chk(two_v, w & 13'h008F);
      default: chk(ext_three_word, w);
    endcase
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    // deselect edges with cke high so the first write sees cke high before it
    u_ctl.issue(4'hF, 3'h0, 13'h0000, 1'b1);
    wchk(2'h2, 13'h0087);
    wchk(2'h3, 13'h0000);
    wchk(2'h1, 13'h0000);
    wchk(2'h0, 13'h0100);
    $display("init done");
    for (int i = 0; i < 8; i++)
      wchk(2'h0, {1'b0, i[2:0], 2'b00, i[2:0], i[0], 2'b01, ~i[1]});
    u_ctl.issue(4'h0, 3'h4, 13'h0FFF, 1'b1);
    chk(main_v, 13'h0E7A);
    $display("main done");
    wchk(2'h1, 13'h1438);
    wchk(2'h1, 13'h0046);
    wchk(2'h1, 13'h0398);
    u_ctl.issue(4'h0, 3'h1, 13'h0228, 1'b1);
    chk(one_v, 13'h0218);
    wchk(2'h1, 13'h0018);
    $display("register one done");
    u_ctl.issue(4'h1, 3'h0, 13'h0000, 1'b0);
    chk({11'h000, self_refresh, dll_enable}, 13'h0002);
    u_ctl.issue(4'hF, 3'h0, 13'h0000, 1'b1);
    chk({11'h000, self_refresh, dll_enable}, 13'h0001);
    $display("self refresh done");
    conclude();
  end
endmodule
